// File: bench/dcc_comp_model.sv
// dcc_comp_model: behavioural pair of analog comparators.
// assumes the bench commands which input is higher; powered state comes from the block.
`timescale 1ns/1ps
`default_nettype none
module dcc_comp_model (
   input  wire logic clk_in,
   input  wire logic first_en_in,
   input  wire logic second_en_in,
   input  wire logic first_want_in,
   input  wire logic second_want_in,
   output logic      first_raw_out,
   output logic      second_raw_out
);
   logic tog_q = 1'b0;
   // an unpowered comparator has no valid level, so a changing pattern stands in
   always_ff @(posedge clk_in) tog_q <= ~tog_q;
   // high when plus input is above minus input
   assign first_raw_out  = first_en_in ? first_want_in : tog_q;
   assign second_raw_out = second_en_in ? second_want_in : ~tog_q;
endmodule
`default_nettype wire

// File: bench/dcc_top_props.sv
// dcc_top_props: port-level checker for the dual comparator control block.
// assumes it is bound onto dcc_top and sees every software write on the register port.
`timescale 1ns/1ps
`default_nettype none
module dcc_top_props
   import dcc_pkg::*;
(
   input wire logic       clk_in, rst_in, wr_in, rd_in, first_raw_in, second_raw_in, sleep_in,
   input wire logic [7:0] addr_in, wdata_in, rdata_out, pin_drive_out, pin_oe_out,
   input wire logic       first_enable_out, second_enable_out, ref_to_plus_out, minus_sel_high_out,
   input wire logic       irq_out, wake_out
);
   // ************************************************************
   // shadow registers and properties
   // ************************************************************
   logic [7:0] ctl_q;   // control copy
   logic [7:0] en_q;    // enables copy
   logic [7:0] ic_q;    // interrupt control copy
   // shadows follow writes only, so a stuck design register shows up as a mismatch
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctl_q <= 8'h07;
         en_q  <= 8'h00;
         ic_q  <= 8'h00;
      end else if (wr_in) begin
         if (addr_in == DCC_COMPARATOR_CONTROL_ADDR) ctl_q <= {2'b00, wdata_in[5:0]};
         if (addr_in == DCC_PERIPH_ENABLES_TWO_ADDR) en_q <= wdata_in;
         if (addr_in == DCC_INTERRUPT_CONTROL_ADDR) ic_q <= wdata_in;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_ref_plus: assert property (ref_to_plus_out == (ctl_q[2:0] == 3'h6))
      else $error("reference routing wrong");
   a_minus_sel: assert property (minus_sel_high_out == (ctl_q[2:0] == 3'h6 && ctl_q[3]))
      else $error("minus input select wrong");
   a_off_power: assert property (ctl_q[2:0] == 3'h7 |-> !first_enable_out && !second_enable_out)
      else $error("comparator powered in off mode");
   a_oe_follow: assert property (wr_in && addr_in == DCC_PORT_A_DIRECTION_ADDR |=> pin_oe_out == ~$past(wdata_in))
      else $error("pin enable does not follow direction");
   a_pin_mux: assert property (ctl_q[2:0] == 3'h5 |->
      pin_drive_out[5:4] == {second_raw_in ^ ctl_q[5], first_raw_in ^ ctl_q[4]}) else $error("pin output not raw");
   a_irq_gate: assert property (irq_out |-> en_q[6] && ic_q[7] && ic_q[6])
      else $error("interrupt without enables");
   a_wake_sleep: assert property (wake_out |-> sleep_in && en_q[6])
      else $error("wake outside sleep");
   a_ctl_read: assert property (rd_in && addr_in == DCC_COMPARATOR_CONTROL_ADDR && ctl_q[2:0] == 3'h7
      |=> rdata_out == {2'b00, ctl_q[5:0]}) else $error("control read wrong");
   a_ref_bit4: assert property (rd_in && addr_in == DCC_REFERENCE_CONTROL_ADDR |=> !rdata_out[4])
      else $error("reference bit 4 not zero");
endmodule
bind dcc_top dcc_top_props u_props (.clk_in, .rst_in, .wr_in, .rd_in, .first_raw_in, .second_raw_in, .sleep_in,
   .addr_in, .wdata_in, .rdata_out, .pin_drive_out, .pin_oe_out, .first_enable_out, .second_enable_out,
   .ref_to_plus_out, .minus_sel_high_out, .irq_out, .wake_out);
`default_nettype wire

// File: bench/dual_comparator_control_bench.sv
// dual_comparator_control_bench: self-checking bench for dcc_top.
// assumes a 10 MHz clock and a register master that never waits.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module dual_comparator_control_bench;
   import dcc_pkg::*;
   // ************************************************************
   // stimulus and checks
   // ************************************************************
   logic       clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, sleep_in = 1'b0, w1 = 1'b0, w2 = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, pin_level_in = 8'h00, rdata_out, pin_drive_out, pin_oe_out, got, d;
   logic       first_raw_in, second_raw_in, first_enable_out, second_enable_out, ref_to_plus_out, minus_sel_high_out;
   logic       irq_out, wake_out;
   logic [7:0] ref_out;
   logic [7:0] ra [6] = '{8'h9c, 8'h9d, 8'h0d, 8'h8d, 8'h85, 8'h10};
   logic [7:0] rv [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
   int         n_mismatch = 0, checks = 0, seed = 96, cyc = 0;
   always #50 clk_in = ~clk_in;
   dcc_top u_dut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .first_raw_in, .second_raw_in,
      .first_enable_out, .second_enable_out, .ref_to_plus_out, .minus_sel_high_out, .reference_control_out(ref_out),
      .pin_level_in, .pin_drive_out, .pin_oe_out, .sleep_in, .irq_out, .wake_out);
   dcc_comp_model u_model (.clk_in, .first_en_in(first_enable_out), .second_en_in(second_enable_out),
      .first_want_in(w1), .second_want_in(w2), .first_raw_out(first_raw_in), .second_raw_out(second_raw_in));
   // analog pins read zero; mode 001 keeps pin 3 digital
   function automatic logic [7:0] port_exp(input int m, input logic [7:0] lvl);
      port_exp = (m == 7) ? lvl : (m == 1) ? (lvl & 8'hf8) : (lvl & 8'hf0);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_in);
      wr_in <= 1'b1; addr_in <= a; wdata_in <= v;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      rd_in <= 1'b1; addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 got = rdata_out;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (ra[i]) begin rd(ra[i]); `CHK("reset value", rv[i], got) end
      wr(8'h9c, 8'hff); rd(8'h9c); `CHK("control", 8'h3f, got)
      wr(8'h9d, 8'hff); rd(8'h9d); `CHK("reference", 8'hef, got)
      `CHK("reference out", 8'hef, ref_out)
      $display("test registers done");
      for (int m = 0; m < 8; m++) begin
         d = {4'h0, 1'($random(seed)), 3'(m)};
         wr(8'h9c, d);
         `CHK("ref routing", m == 6, ref_to_plus_out)
         `CHK("minus select", m == 6 && d[3], minus_sel_high_out)
         `CHK("first power", m != 7, first_enable_out)
         `CHK("second power", m != 7 && m != 0, second_enable_out)
         pin_level_in <= 8'($random(seed));
         repeat (5) @(posedge clk_in);
         rd(8'h05); `CHK("port read", port_exp(m, pin_level_in), got)
      end
      $display("test modes done");
      for (int k = 0; k < 4; k++) begin
         d = {2'b00, 2'($random(seed)), 4'h2};
         // change enable is still clear here, so a mode change cannot raise a false interrupt
         wr(8'h9c, d); w1 <= k[0]; w2 <= k[1];
         repeat (6) @(posedge clk_in);
         rd(8'h9c); `CHK("results", {k[1] ^ d[5], k[0] ^ d[4], d[5:0]}, got)
         wr(8'h0d, 8'h00); rd(8'h0d); `CHK("flag cleared", 8'h00, got)
         w1 <= ~w1;
         repeat (6) @(posedge clk_in);
         rd(8'h0d); `CHK("flag on change", 8'h40, got)
      end
      rd(8'h9c); wr(8'h0d, 8'h00); wr(8'h0d, 8'h40); rd(8'h0d); `CHK("soft flag", 8'h40, got)
      for (int e = 0; e < 8; e++) begin
         wr(8'h8d, {1'b0, e[0], 6'h00}); wr(8'h0b, {e[2], e[1], 6'h00});
         `CHK("irq", &e[2:0], irq_out)
         sleep_in <= 1'b1;
         #1 `CHK("wake", e[0], wake_out)
         sleep_in <= 1'b0;
      end
      // off mode before sleep powers both comparators down; sleep keeps the register
      wr(8'h9c, 8'h07); sleep_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CHK("sleep power", 1'b0, first_enable_out | second_enable_out)
      rd(8'h9c); `CHK("control in sleep", 8'h07, got)
      sleep_in <= 1'b0;
      $display("test interrupts done");
      d = {2'b00, 2'($random(seed)), 4'h5};
      wr(8'h9c, d); wr(8'h85, 8'h0f);
      `CHK("pin enable", 8'hf0, pin_oe_out)
      w1 <= 1'($random(seed)); w2 <= 1'($random(seed));
      #1 `CHK("pin drive", {w2 ^ d[5], w1 ^ d[4]}, pin_drive_out[5:4])
      $display("test pins done");
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(8'h9c); `CHK("control after reset", 8'h07, got)
      $display("test second reset done");
      finish_test();
   end
endmodule
`default_nettype wire

// File: rtl/dcc_pkg.sv
// dcc_pkg: register map, field positions, reset values and mode codes
// for the dual comparator control block.
// assumes an 8-bit register port with byte offsets as printed.
package dcc_pkg;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] DCC_PORT_A_DATA_ADDR      = 8'h05;
   localparam logic [7:0] DCC_INTERRUPT_CONTROL_ADDR = 8'h0b;
   localparam logic [7:0] DCC_PERIPH_FLAGS_TWO_ADDR = 8'h0d;
   localparam logic [7:0] DCC_PORT_A_DIRECTION_ADDR = 8'h85;
   localparam logic [7:0] DCC_PERIPH_ENABLES_TWO_ADDR = 8'h8d;
   localparam logic [7:0] DCC_COMPARATOR_CONTROL_ADDR = 8'h9c;
   localparam logic [7:0] DCC_REFERENCE_CONTROL_ADDR = 8'h9d;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int DCC_SECOND_RESULT_BIT = 7;
   localparam int DCC_FIRST_RESULT_BIT  = 6;
   localparam int DCC_SECOND_INVERT_BIT = 5;
   localparam int DCC_FIRST_INVERT_BIT  = 4;
   localparam int DCC_INPUT_SWITCH_BIT  = 3;
   localparam int DCC_CHANGE_FLAG_BIT   = 6;   // flag/enable registers
   localparam int DCC_GLOBAL_IRQ_BIT    = 7;
   localparam int DCC_PERIPH_IRQ_BIT    = 6;
   localparam int DCC_FIRST_PIN_BIT     = 4;
   localparam int DCC_SECOND_PIN_BIT    = 5;

   // ************************************************************
   // reset values and writable masks
   // ************************************************************
   localparam logic [7:0] DCC_COMPARATOR_CONTROL_RST = 8'h07;
   localparam logic [7:0] DCC_REFERENCE_CONTROL_RST  = 8'h00;
   localparam logic [7:0] DCC_REFERENCE_CONTROL_MASK = 8'hef;
   localparam logic [7:0] DCC_FLAGS_ENABLES_RST      = 8'h00;
   localparam logic [7:0] DCC_FLAGS_ENABLES_MASK     = 8'he3;
   localparam logic [7:0] DCC_PORT_A_DIRECTION_RST   = 8'hff;
   localparam logic [7:0] DCC_INTERRUPT_CONTROL_RST  = 8'h00;
   localparam logic [7:0] DCC_PORT_A_DATA_RST        = 8'h00;

   // ************************************************************
   // comparator modes
   // ************************************************************
   typedef enum logic [2:0] {
      DCC_MODE_0      = 3'h0,
      DCC_MODE_1      = 3'h1,
      DCC_MODE_2      = 3'h2,
      DCC_MODE_3      = 3'h3,
      DCC_MODE_4      = 3'h4,
      DCC_MODE_PINOUT = 3'h5,
      DCC_MODE_INTREF = 3'h6,
      DCC_MODE_OFF    = 3'h7
   } dcc_mode_t;

   // analog input mask (pins 0..3) per mode; 1 = analog
   function automatic logic [7:0] dcc_analog_mask(input logic [2:0] mode);
      case (mode)
         3'h7:    dcc_analog_mask = 8'h00;
         3'h6:    dcc_analog_mask = 8'h0f;
         3'h5:    dcc_analog_mask = 8'h0f;
         3'h4:    dcc_analog_mask = 8'h0f;
         3'h3:    dcc_analog_mask = 8'h0f;
         3'h2:    dcc_analog_mask = 8'h0f;
         3'h1:    dcc_analog_mask = 8'h07;
         default: dcc_analog_mask = 8'h0f;
      endcase
   endfunction

endpackage

// File: rtl/dcc_top.sv
// dcc_top: control and status logic for two analog comparators.
// assumes raw comparator outputs arrive asynchronously from analog cells,
// and that the cpu core drives the register port and the sleep input.
//
// How it works
// - mode 110 routes internal reference to both non-inverting inputs.
// - result bits 7:6 of comparator control read only, writes ignored.
// - pin output mode drives pins straight from comparator, unsynchronised.
// - direction bits still gate the pin drivers in pin output mode.
// - invert bits 5:4 flip each comparator's reported polarity.
// - port data reads return 0 on pins configured analog.
// - flag sets whenever either comparator output changes.
// - software writing 0 clears flag, writing 1 sets it.
// - interrupt needs own, peripheral and global enables; flag sets anyway.
// - change coinciding with control register read may miss the flag.
// - mismatch keeps setting flag until control register read or written.
// - comparators keep working in sleep; enabled interrupt wakes device.
// - wake from sleep leaves comparator control unchanged.
// - every reset loads comparator control with 0x07, mode off.
// - reference control resets to zero, bit 4 reads zero.
// - in mode 110 input switch picks pins 3/2 or pins 0/1.
// - result is 1 when plus exceeds minus, flipped by invert.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module dcc_top
   import dcc_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // register port
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   // analog side
   input  wire logic       first_raw_in,
   input  wire logic       second_raw_in,
   output logic            first_enable_out,
   output logic            second_enable_out,
   output logic            ref_to_plus_out,
   output logic            minus_sel_high_out,
   output logic      [7:0] reference_control_out,
   // port pins
   input  wire logic [7:0] pin_level_in,
   output logic      [7:0] pin_drive_out,
   output logic      [7:0] pin_oe_out,
   // core side
   input  wire logic       sleep_in,
   output logic            irq_out,
   output logic            wake_out
);

   // ************************************************************
   // registers
   // ************************************************************
   logic [5:0] cmp_ctrl_q;       // invert bits, input switch, mode
   logic [7:0] ref_ctrl_q;
   logic [7:0] flags_q;
   logic [7:0] enables_q;
   logic [7:0] intctl_q;
   logic [7:0] dir_q;
   logic [7:0] port_latch_q;
   logic [1:0] latched_q;        // result seen by last control access
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [7:0] pin_s1_q;
   logic [7:0] pin_s2_q;
   logic [7:0] pin_s3_q;
   logic [7:0] rdata_q;

   logic [2:0] mode;
   logic [1:0] live_raw;
   logic [1:0] live;
   logic       cmp_off;
   logic       pin_mode;
   logic       ctrl_access;
   logic       mismatch;
   logic       flag_set;
   logic [7:0] pin_value;

   assign mode        = cmp_ctrl_q[2:0];
   assign cmp_off     = (mode == DCC_MODE_OFF);
   assign pin_mode    = (mode == DCC_MODE_PINOUT);
   assign ctrl_access = (wr_in || rd_in) && (addr_in == DCC_COMPARATOR_CONTROL_ADDR);

   // ************************************************************
   // analog steering
   // ************************************************************
   // analog cells stay enabled during sleep; mode off powers both down, mode 000 powers down the second
   assign first_enable_out      = !cmp_off;
   assign second_enable_out     = !cmp_off && (mode != DCC_MODE_0);
   assign ref_to_plus_out       = (mode == DCC_MODE_INTREF);
   assign minus_sel_high_out    = ref_to_plus_out && cmp_ctrl_q[DCC_INPUT_SWITCH_BIT];
   assign reference_control_out = ref_ctrl_q;

   // ************************************************************
   // result synchronisers
   // ************************************************************
   // three stages; a change is taken once stages two and three agree
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
      end else begin
         s1_q <= {s1_q[1:0], first_raw_in};
         s2_q <= {s2_q[1:0], second_raw_in};
      end
   end

   // raw is high when plus exceeds minus; invert flips sense
   assign live_raw = {(s2_q[1] == s2_q[2]) ? s2_q[2] : latched_q[1] ^ cmp_ctrl_q[DCC_SECOND_INVERT_BIT],
                      (s1_q[1] == s1_q[2]) ? s1_q[2] : latched_q[0] ^ cmp_ctrl_q[DCC_FIRST_INVERT_BIT]};
   // off mode reads zero on both results
   assign live = cmp_off ? 2'h0 :
                 live_raw ^ {cmp_ctrl_q[DCC_SECOND_INVERT_BIT], cmp_ctrl_q[DCC_FIRST_INVERT_BIT]};

   // ************************************************************
   // mismatch latch and change flag
   // ************************************************************
   // any control access refreshes the latch and so ends the mismatch
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         latched_q <= 2'h0;
      end else if (ctrl_access) begin
         latched_q <= live;
      end
   end

   // during the access cycle itself the compare is suppressed, so a change
   // landing exactly there may be absorbed into the latch without a flag
   assign mismatch = (live != latched_q) && !ctrl_access;
   assign flag_set = mismatch;

   // flag sets regardless of enables; hardware set beats software clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flags_q <= DCC_FLAGS_ENABLES_RST;
      end else begin
         if (wr_in && addr_in == DCC_PERIPH_FLAGS_TWO_ADDR) begin
            flags_q <= wdata_in & DCC_FLAGS_ENABLES_MASK;
         end
         if (flag_set) begin
            flags_q[DCC_CHANGE_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // ************************************************************
   // software registers
   // ************************************************************
   // sleep is not a reset, so nothing here reacts to it
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cmp_ctrl_q <= DCC_COMPARATOR_CONTROL_RST[5:0];
      end else if (wr_in && addr_in == DCC_COMPARATOR_CONTROL_ADDR) begin
         cmp_ctrl_q <= wdata_in[5:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_ctrl_q <= DCC_REFERENCE_CONTROL_RST;
      end else if (wr_in && addr_in == DCC_REFERENCE_CONTROL_ADDR) begin
         ref_ctrl_q <= wdata_in & DCC_REFERENCE_CONTROL_MASK;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         enables_q <= DCC_FLAGS_ENABLES_RST;
      end else if (wr_in && addr_in == DCC_PERIPH_ENABLES_TWO_ADDR) begin
         enables_q <= wdata_in & DCC_FLAGS_ENABLES_MASK;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         intctl_q <= DCC_INTERRUPT_CONTROL_RST;
      end else if (wr_in && addr_in == DCC_INTERRUPT_CONTROL_ADDR) begin
         intctl_q <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dir_q <= DCC_PORT_A_DIRECTION_RST;
      end else if (wr_in && addr_in == DCC_PORT_A_DIRECTION_ADDR) begin
         dir_q <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         port_latch_q <= DCC_PORT_A_DATA_RST;
      end else if (wr_in && addr_in == DCC_PORT_A_DATA_ADDR) begin
         port_latch_q <= wdata_in;
      end
   end

   // ************************************************************
   // port pins
   // ************************************************************
   // pin outputs bypass the synchroniser on purpose: lowest latency,
   // at the cost of glitches while the comparator settles
   always_comb begin
      pin_drive_out = port_latch_q;
      if (pin_mode) begin
         pin_drive_out[DCC_FIRST_PIN_BIT]  = first_raw_in ^ cmp_ctrl_q[DCC_FIRST_INVERT_BIT];
         pin_drive_out[DCC_SECOND_PIN_BIT] = second_raw_in ^ cmp_ctrl_q[DCC_SECOND_INVERT_BIT];
      end
   end
   assign pin_oe_out = ~dir_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_s1_q <= 8'h00;
         pin_s2_q <= 8'h00;
         pin_s3_q <= 8'h00;
      end else begin
         pin_s1_q <= pin_level_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // a bit changes once stages two and three agree, otherwise old value holds
   logic [7:0] pin_held_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_held_q <= 8'h00;
      end else begin
         pin_held_q <= pin_value;
      end
   end
   assign pin_value = (pin_s2_q & pin_s3_q) | (pin_held_q & (pin_s2_q ^ pin_s3_q));

   // ************************************************************
   // interrupt and wake
   // ************************************************************
   assign wake_out = sleep_in && flags_q[DCC_CHANGE_FLAG_BIT] && enables_q[DCC_CHANGE_FLAG_BIT];
   assign irq_out  = flags_q[DCC_CHANGE_FLAG_BIT] && enables_q[DCC_CHANGE_FLAG_BIT]
                     && intctl_q[DCC_PERIPH_IRQ_BIT] && intctl_q[DCC_GLOBAL_IRQ_BIT];

   // ************************************************************
   // read data, one cycle after the strobe
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            DCC_COMPARATOR_CONTROL_ADDR: rdata_q <= {live, cmp_ctrl_q};
            DCC_REFERENCE_CONTROL_ADDR:  rdata_q <= ref_ctrl_q;
            DCC_PERIPH_FLAGS_TWO_ADDR:   rdata_q <= flags_q;
            DCC_PERIPH_ENABLES_TWO_ADDR: rdata_q <= enables_q;
            DCC_INTERRUPT_CONTROL_ADDR:  rdata_q <= intctl_q;
            DCC_PORT_A_DIRECTION_ADDR:   rdata_q <= dir_q;
            DCC_PORT_A_DATA_ADDR:        rdata_q <= pin_value & ~dcc_analog_mask(mode);
            default:                     rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata_out = rdata_q;

endmodule

`default_nettype wire
